// ===== logic/srs_defines.vh
`ifndef SRS_DEFINES_VH
`define SRS_DEFINES_VH

// Status register select codes
`define SRS_SEL_G1_OVERLOAD 2'h0
`define SRS_SEL_G1_OPEN_LOAD 2'h1
`define SRS_SEL_G2_OVERLOAD 2'h2
`define SRS_SEL_G2_OPEN_LOAD 2'h3
`define SRS_SEL_RESET 2'h0
`define SRS_REG_COUNT 4
`define SRS_REG_LAST 3

// Frame layout
`define SRS_FRAME_W 16
`define SRS_FRAME_MSB 15
`define SRS_RX_CLEAR_BIT 2
`define SRS_RX_SEL_HI 1
`define SRS_RX_SEL_LO 0

// Status word layout: diagnosis field sits in bits 15..6
`define SRS_DIAG_W 10
`define SRS_DIAG_MSB 9
`define SRS_DIAG_ZERO 10'h000

// Diagnosis input vector positions after synchronisation
`define SRS_IN_W 18
`define SRS_IN_LS_OVL 17:15
`define SRS_IN_HS_OVL 14:9
`define SRS_IN_LS_OPL 8:6
`define SRS_IN_HS_OPL 5:3
`define SRS_IN_SUPPLY 2
`define SRS_IN_THERMAL 1
`define SRS_IN_WARN 0
`define SRS_IN_RESET 18'h00000

// Switch indices inside the vectors
`define SRS_SW_4 0
`define SRS_SW_5 1
`define SRS_SW_6 2
`define SRS_HS_7 3
`define SRS_HS_8 4
`define SRS_HS_10 5
`define SRS_OPL_HS_7 0
`define SRS_OPL_HS_8 1
`define SRS_OPL_HS_10 2

`define SRS_WORD_RESET 16'h0000

`endif

// ===== logic/srs_status_port.v
// Summary of operation
// - Each frame returns sixteen status bits preceded by one summary error bit.
// - Select code 00..11 picks group one/two overload or open-load register.
// - Unassigned and test-reserved status bits always read low.
// - Overload bit goes high when a switch shuts down on overload conditions.
// - Open-load bit goes high when undercurrent is detected on a switch.
// - Bit 5 of every register is the supply-fail flag.
// - Bit 4 of every register is the thermal-shutdown flag.
// - Bit 3 of every register is the temperature-warning flag.
// - Bits 2..0 are error flags of the other three registers, as tabulated.
// - Received data acts internally only when chip select rises.
// - Address sent in one frame; that register is returned next frame.
// - After reset the readout address is 00.
// - A clear request acts after the following frame, once contents were read.
// - Select bits plus clear bit form one read-and-maybe-clear command.
// - Clearing any register also clears the thermal-shutdown flag.
// - Summary error bit drives data out after chip select falls, before clock.
// - Summary error bit is the OR of the four per-register error flags.
// - The port chains like a shift register; data out follows data in after the flag and status word.
// - Input bit 2 is the clear request for the selected register.
// - Input bits 1..0 are the register select code.
`timescale 1ns/1ps
`default_nettype none
`include "srs_defines.vh"

module srs_status_port (
   // System
   input wire clock,
   input wire rst,
   // Serial pins; inputs asynchronous to clock, outputs registered on clock
   input wire chipSelectN,
   input wire serialClk,
   input wire serialIn,
   output reg serialOut,
   output reg serialOutEnable,
   // Diagnosis events: index 0..2 = switch 4..6
   input wire [2:0] lowSideOverload,
   // High-side order: 4, 5, 6, 7, 8, 10
   input wire [5:0] highSideOverload,
   input wire [2:0] lowSideOpenLoad,
   // High-side open-load order: 7, 8, 10
   input wire [2:0] highSideOpenLoad,
   // Flags: supply and warning read live, thermal shutdown is latched
   input wire supplyFail,
   input wire thermalShutdown,
   input wire temperatureWarning
);

   // Other three flags in descending order, skipping the register's own
   function [2:0] otherFlags;
      input [1:0] sel;
      input [3:0] flags;
      begin
         case (sel)
            `SRS_SEL_G1_OVERLOAD:
            begin
               otherFlags = {flags[3], flags[2], flags[1]};
            end
            `SRS_SEL_G1_OPEN_LOAD:
            begin
               otherFlags = {flags[3], flags[2], flags[0]};
            end
            `SRS_SEL_G2_OVERLOAD:
            begin
               otherFlags = {flags[3], flags[1], flags[0]};
            end
            default:
            begin
               otherFlags = {flags[2], flags[1], flags[0]};
            end
         endcase
      end
   endfunction

   // Per-register error flag: any diagnosis bit held
   function anySet;
      input [`SRS_DIAG_MSB:0] bits;
      begin
         anySet = |bits;
      end
   endfunction

   // Two-flop synchronisers for the serial pins; edge history resets to idle levels
   reg csMeta;
   reg csSync;
   reg csLast;
   reg clkMeta;
   reg clkSync;
   reg clkLast;
   reg dinMeta;
   reg dinSync;

   always @(posedge clock)
   begin
      if (rst)
      begin
         csMeta <= 1'b1;
         csSync <= 1'b1;
         csLast <= 1'b1;
         clkMeta <= 1'b0;
         clkSync <= 1'b0;
         clkLast <= 1'b0;
         dinMeta <= 1'b0;
         dinSync <= 1'b0;
      end
      else
      begin
         csMeta <= chipSelectN;
         csSync <= csMeta;
         csLast <= csSync;
         clkMeta <= serialClk;
         clkSync <= clkMeta;
         clkLast <= clkSync;
         dinMeta <= serialIn;
         dinSync <= dinMeta;
      end
   end

   // Detector levels come from unclocked monitors, so they are synchronised too
   reg [`SRS_IN_W-1:0] diagMeta;
   reg [`SRS_IN_W-1:0] diagSync;

   always @(posedge clock)
   begin
      if (rst)
      begin
         diagMeta <= `SRS_IN_RESET;
         diagSync <= `SRS_IN_RESET;
      end
      else
      begin
         diagMeta <= {lowSideOverload, highSideOverload, lowSideOpenLoad,
                      highSideOpenLoad, supplyFail, thermalShutdown, temperatureWarning};
         diagSync <= diagMeta;
      end
   end

   wire frameStart = csLast & ~csSync;
   wire frameEnd = ~csLast & csSync;
   wire inFrame = ~csSync;
   wire clkRise = inFrame & clkSync & ~clkLast;
   wire clkFall = inFrame & ~clkSync & clkLast;

   wire [2:0] lsOvl = diagSync[`SRS_IN_LS_OVL];
   wire [5:0] hsOvl = diagSync[`SRS_IN_HS_OVL];
   wire [2:0] lsOpl = diagSync[`SRS_IN_LS_OPL];
   wire [2:0] hsOpl = diagSync[`SRS_IN_HS_OPL];

   // Set vectors per register; zero positions are never set
   wire [`SRS_DIAG_MSB:0] setVec [0:`SRS_REG_LAST];
   assign setVec[0] = {6'h00, hsOvl[`SRS_HS_7], 3'h0};
   assign setVec[1] = {6'h00, hsOpl[`SRS_OPL_HS_7], 3'h0};
   assign setVec[2] = {lsOvl[`SRS_SW_4], hsOvl[`SRS_SW_4], lsOvl[`SRS_SW_5],
                       hsOvl[`SRS_SW_5], lsOvl[`SRS_SW_6], hsOvl[`SRS_SW_6],
                       hsOvl[`SRS_HS_8], 1'b0, hsOvl[`SRS_HS_10], 1'b0};
   assign setVec[3] = {lsOpl[`SRS_SW_4], 1'b0, lsOpl[`SRS_SW_5], 1'b0,
                       lsOpl[`SRS_SW_6], 1'b0, hsOpl[`SRS_OPL_HS_8], 1'b0,
                       hsOpl[`SRS_OPL_HS_10], 1'b0};

   // Sticky diagnosis bits, thermal latch and command state
   reg [`SRS_DIAG_MSB:0] diag [0:`SRS_REG_LAST];
   reg thermalLatch;
   reg [1:0] readSel;
   reg clearPending;
   reg [`SRS_FRAME_MSB:0] rxShift;
   reg [`SRS_FRAME_MSB:0] txShift;
   reg rxBit;
   integer k;

   // Clear only at frame end, for the register that was just read out
   wire doClear = frameEnd & clearPending;

   // Sticky update; an event in the clearing cycle survives the clear
   function [`SRS_DIAG_MSB:0] stickyNext;
      input [`SRS_DIAG_MSB:0] held;
      input [`SRS_DIAG_MSB:0] events;
      input wipe;
      begin
         if (wipe)
         begin
            stickyNext = events;
         end
         else
         begin
            stickyNext = held | events;
         end
      end
   endfunction

   always @(posedge clock)
   begin
      if (rst)
      begin
         for (k = 0; k < `SRS_REG_COUNT; k = k + 1)
         begin
            diag[k] <= `SRS_DIAG_ZERO;
         end
      end
      else
      begin
         for (k = 0; k < `SRS_REG_COUNT; k = k + 1)
         begin
            diag[k] <= stickyNext(diag[k], setVec[k], doClear && (readSel == k[1:0]));
         end
      end
   end

   // Thermal latch is address independent, so any clear wipes it
   always @(posedge clock)
   begin
      if (rst)
      begin
         thermalLatch <= 1'b0;
      end
      else if (doClear)
      begin
         thermalLatch <= diagSync[`SRS_IN_THERMAL];
      end
      else
      begin
         thermalLatch <= thermalLatch | diagSync[`SRS_IN_THERMAL];
      end
   end

   wire [3:0] regError;
   assign regError[0] = anySet(diag[0]);
   assign regError[1] = anySet(diag[1]);
   assign regError[2] = anySet(diag[2]);
   assign regError[3] = anySet(diag[3]);
   wire summaryError = |regError;

   wire [`SRS_FRAME_MSB:0] statusWord = {diag[readSel],
                                         diagSync[`SRS_IN_SUPPLY],
                                         thermalLatch,
                                         diagSync[`SRS_IN_WARN],
                                         otherFlags(readSel, regError)};

   // Command register: only committed when chip select rises
   always @(posedge clock)
   begin
      if (rst)
      begin
         readSel <= `SRS_SEL_RESET;
         clearPending <= 1'b0;
      end
      else if (frameEnd)
      begin
         readSel <= rxShift[`SRS_RX_SEL_HI:`SRS_RX_SEL_LO];
         clearPending <= rxShift[`SRS_RX_CLEAR_BIT];
      end
   end

   // Enable follows the synchronised select, so it lags the pin by three cycles
   always @(posedge clock)
   begin
      if (rst)
      begin
         serialOutEnable <= 1'b0;
      end
      else
      begin
         serialOutEnable <= inFrame;
      end
   end

   // Transmit side: flag at frame start, then one bit per falling serial clock
   always @(posedge clock)
   begin
      if (rst)
      begin
         txShift <= `SRS_WORD_RESET;
         serialOut <= 1'b0;
      end
      else if (frameStart)
      begin
         serialOut <= summaryError;
         txShift <= statusWord;
      end
      else if (clkFall)
      begin
         // Received bits follow the status word out, for chaining
         serialOut <= txShift[`SRS_FRAME_MSB];
         txShift <= {txShift[`SRS_FRAME_MSB-1:0], rxBit};
      end
      else if (!inFrame)
      begin
         serialOut <= 1'b0;
      end
   end

   // Receive side: sample on the rising serial clock; longer frames keep the last bits
   always @(posedge clock)
   begin
      if (rst)
      begin
         rxShift <= `SRS_WORD_RESET;
         rxBit <= 1'b0;
      end
      else if (clkRise)
      begin
         rxBit <= dinSync;
         rxShift <= {rxShift[`SRS_FRAME_MSB-1:0], dinSync};
      end
   end

endmodule // srs_status_port

`default_nettype wire

// ===== dv/srs_status_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module srs_status_port_sva (
   // System
   input wire logic clock,
   input wire logic rst,
   // Serial pins
   input wire logic chipSelectN,
   input wire logic serialClk,
   input wire logic serialOut,
   input wire logic serialOutEnable
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence frameOpen;
      $fell(chipSelectN) ##1 !chipSelectN [*2];
   endsequence
   sequence clkRise;
      $rose(serialClk) && !chipSelectN;
   endsequence
   a_flag_early: assert property (frameOpen |-> ##[0:2] serialOutEnable)
      else $error("flag not driven");
   a_enable_idle: assert property (chipSelectN [*5] |-> !serialOutEnable)
      else $error("enable outside frame");
   a_out_idle_low: assert property (chipSelectN [*6] |-> !serialOut)
      else $error("data outside frame");
   a_hold_clk_high: assert property (clkRise |-> ##2 $stable(serialOut) [*3])
      else $error("data moved on rise");
   a_rise_in_frame: assert property ($rose(serialOut) |-> serialOutEnable)
      else $error("data rose unselected");
   a_enable_cause: assert property ($rose(serialOutEnable) |-> !chipSelectN && !$past(chipSelectN))
      else $error("enable without select");
   a_enable_release: assert property ($rose(chipSelectN) |-> ##[2:5] !serialOutEnable)
      else $error("enable stuck");
   a_reset_quiet: assert property ($fell(rst) |-> !serialOut && !serialOutEnable)
      else $error("outputs after reset");
endmodule // srs_status_port_sva
bind srs_status_port srs_status_port_sva chk_u (.clock(clock), .rst(rst), .chipSelectN(chipSelectN),
   .serialClk(serialClk), .serialOut(serialOut), .serialOutEnable(serialOutEnable));
`default_nettype wire

// ===== dv/srs_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module srs_spi_master (
   // System
   input wire logic clock,
   // Serial pins
   output logic chipSelectN,
   output logic serialClk,
   output logic serialIn,
   input wire logic serialOut
);
   initial
   begin
      chipSelectN = 1'b1;
      serialClk = 1'b0;
      serialIn = 1'b0;
   end
   // Link clock stands still between frames; released data line toggles so no stale bit looks valid
   // A frame of len clocks; rx[len] is the flag, bits beyond sixteen come back through the chain
   task automatic frame(input logic [31:0] cmd, input int len, output logic [32:0] rx);
      rx = '0;
      @(posedge clock);
      chipSelectN <= 1'b0;
      serialIn <= cmd[len - 1];
      repeat (5) @(posedge clock);
      for (int i = len; i >= 1; i--)
      begin
         rx[i] = serialOut;
         serialClk <= 1'b1;
         repeat (4) @(posedge clock);
         serialClk <= 1'b0;
         serialIn <= (i > 1) ? cmd[i - 2] : ~serialIn;
         repeat (4) @(posedge clock);
      end
      rx[0] = serialOut;
      chipSelectN <= 1'b1;
      serialIn <= ~serialIn;
      repeat (130) @(posedge clock);
   endtask
endmodule // srs_spi_master
`default_nettype wire

// ===== dv/tb_srs_status_port.sv
`timescale 1ns/1ps
`default_nettype none
`define SRS_CHK(g, e) begin checkCount++; if ((g) !== (e)) begin badCount++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_srs_status_port;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [2:0] lsOvl = 3'h0;
   logic [5:0] hsOvl = 6'h00;
   logic [2:0] lsOpl = 3'h0;
   logic [2:0] hsOpl = 3'h0;
   logic supFail = 1'b0;
   logic thermal = 1'b0;
   logic warn = 1'b0;
   wire selN, sClk, sIn, sOut, sOutEn;
   int badCount = 0;
   int checkCount = 0;
   int cycles = 0;
   logic [32:0] rx;
   // Filler in upper bits shows only the low command bits count; the last command is undone by reset
   logic [15:0] cmd [7] = '{16'hA5A9, 16'hA5AA, 16'hA5AB, 16'hA5A8, 16'hA5AC, 16'hA5A8, 16'hA5AE};
   logic [16:0] expv [7] = '{17'h00000, 17'h1023F, 17'h1803F, 17'h1203F, 17'h1023F, 17'h1023F, 17'h10007};
   srs_status_port dut_u (.clock(clock), .rst(rst), .chipSelectN(selN), .serialClk(sClk), .serialIn(sIn),
      .serialOut(sOut), .serialOutEnable(sOutEn), .lowSideOverload(lsOvl), .highSideOverload(hsOvl),
      .lowSideOpenLoad(lsOpl), .highSideOpenLoad(hsOpl), .supplyFail(supFail), .thermalShutdown(thermal),
      .temperatureWarning(warn));
   srs_spi_master mst_u (.clock(clock), .chipSelectN(selN), .serialClk(sClk), .serialIn(sIn), .serialOut(sOut));
   initial
   begin
      forever #20 clock = ~clock;
   end
   task automatic finalReport();
      $display("Checks %0d, errors %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         badCount++;
         $display("ERROR %0t: timeout", $time);
         finalReport();
      end
   end
   initial
   begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      for (int f = 0; f < 7; f++)
      begin
         if (f == 1)
         begin
            hsOvl <= 6'h08;
            hsOpl <= 3'h1;
            lsOvl <= 3'h1;
            lsOpl <= 3'h2;
            thermal <= 1'b1;
            supFail <= 1'b1;
            warn <= 1'b1;
            repeat (4) @(posedge clock);
            {hsOvl, hsOpl, lsOvl, lsOpl, thermal} <= 16'h0000;
         end
         if (f == 6)
         begin
            supFail <= 1'b0;
            warn <= 1'b0;
         end
         mst_u.frame({16'h0000, cmd[f]}, 16, rx);
         `SRS_CHK(rx[16:0], expv[f])
      end
      // Mid-run reset drops select 10, the pending clear and all sticky bits
      rst <= 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      hsOvl <= 6'h08;
      lsOvl <= 3'h1;
      repeat (4) @(posedge clock);
      {hsOvl, lsOvl} <= 9'h000;
      // Long frame: first sixteen bits come back after the status word, last sixteen form the command
      mst_u.frame({16'hC3A6, 16'hA5A9}, 32, rx);
      `SRS_CHK(rx, 33'h10202C3A6)
      mst_u.frame(32'h0000A5A8, 16, rx);
      `SRS_CHK(rx[16:0], 17'h10003)
      finalReport();
   end
endmodule // tb_srs_status_port
`default_nettype wire
